// ===== logic/ibm_pkg.sv
/*
 * Shared constants, carrier structs and state encoding of the two-wire
 * bus master controller.
 * Assumes a 20 MHz system clock and a bus with pull-ups on both wires.
 */
package ibm_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_NS = 50;
    // Half of the bus clock period, 100 kHz standard rate
    localparam int SCL_HALF_NS = 5000;
    // Least time, so rounded up to whole cycles
    localparam int HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;

    // ****************************************************************
    // Framing
    // ****************************************************************
    localparam logic [3:0] DATA_BITS = 4'h8;
    // Index of the acknowledge slot, the ninth clock of a byte
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_STEP = 4'h1;
    // Fixed upper address nibble of the target part, arbitrary value
    localparam logic [3:0] ADDR_FIXED_DFLT = 4'h5;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic start;      // Precede byte by START or repeated START
        logic stop;       // Follow byte by STOP
        logic read;       // Receive byte instead of sending it
        logic nack;       // On read, answer with not-acknowledge
        logic [7:0] data; // Byte to send; address byte carries R/W in bit 0
    } ibm_cmd_type;

    typedef struct packed {
        logic [7:0] data; // Byte seen on the wire
        logic acked;      // Acknowledge slot was low
        logic arb_lost;   // Another master won the bus
    } ibm_rsp_type;

    typedef enum {
        ST_IDLE, ST_RS_LOW, ST_RS_HIGH, ST_START, ST_BIT_LOW,
        ST_BIT_HIGH, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_REL
    } ibm_state_type;

    // Address byte: fixed nibble, three strap bits, then read flag
    function automatic logic [7:0] ibm_addr_byte(
        input logic [3:0] fixed_bits,
        input logic [2:0] strap_bits,
        input logic rd
    );
        return {fixed_bits, strap_bits, rd};
    endfunction : ibm_addr_byte

endpackage : ibm_pkg

// ===== logic/ibm_sync.sv
/*
 * Three-stage synchroniser with agreement filter for bus pin inputs.
 * Assumes inputs are asynchronous to clk_i; output follows the third
 * stage only once the second and third stages agree.
 */
`timescale 1ns/10ps
module ibm_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    // ****************************************************************
    // Per-bit chain
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic filt_ff;
            wire agree = (s2_ff == s3_ff);
            // Released bus idles high, so all stages reset high
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    s1_ff <= 1'b1;
                    s2_ff <= 1'b1;
                    s3_ff <= 1'b1;
                    filt_ff <= 1'b1;
                end else begin
                    s1_ff <= pin_i[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (agree) begin
                        filt_ff <= s3_ff;
                    end
                end
            end
            assign level_o[g] = filt_ff;
        end
    endgenerate

endmodule : ibm_sync

// ===== logic/ibm_tick.sv
/*
 * Half-period enable divider for the bus clock.
 * Assumes clear_i restarts the count so each phase gets a full half period.
 */
`timescale 1ns/10ps
module ibm_tick #(
    parameter int HALF = ibm_pkg::HALF_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic clear_i,
    output logic tick_o
);

    localparam logic [15:0] LAST = 16'(HALF - 1);
    localparam logic [15:0] ZERO = 16'h0000;
    localparam logic [15:0] ONE = 16'h0001;

    logic [15:0] cnt_ff;

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Tick depends on the count alone: the clear is formed from the next
    // state, which itself reads the tick, so gating here would loop
    assign tick_o = (cnt_ff == LAST);

    // Free running between clears, wraps on the tick
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= ZERO;
        end else if (clear_i || tick_o) begin
            cnt_ff <= ZERO;
        end else begin
            cnt_ff <= cnt_ff + ONE;
        end
    end

endmodule : ibm_tick

// ===== logic/ibm_master.sv
/*
 * Byte-level master controller for the shared two-wire bus: START,
 * repeated START, STOP, address and data bytes, acknowledge, clock
 * stretching and arbitration, with bus busy tracking.
 * Assumes pull-ups on both wires and an outside wired-AND of the enables.
 */
`timescale 1ns/10ps
// Behaviour
// - Bytes are eight bits; the receiver answers in a ninth acknowledge slot.
// - Data line changes only while clock is low, except START and STOP.
// - START is data falling while clock high; bus then counts busy.
// - STOP is data rising while clock high; bus then counts free.
// - Data sampled while clock high and held stable through the high phase.
// - Lines are only pulled low or released, and both are monitored.
// - Every transaction opens with START and closes with STOP.
// - Targets have a unique seven or ten bit address.
// - Eighth bit of first byte: high asks read, low announces write.
// - Master releases data on ninth clock; addressed target pulls it low.
// - Clock held low by another node is waited out before continuing.
// - Repeated START keeps the bus busy and acts like START.
module ibm_master #(
    parameter int HALF = ibm_pkg::HALF_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic cmd_valid_i,
    input wire ibm_pkg::ibm_cmd_type cmd_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output ibm_pkg::ibm_rsp_type rsp_o,
    output logic bus_busy_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    ibm_pkg::ibm_state_type state_ff, nxt_state;
    ibm_pkg::ibm_cmd_type cmd_ff;
    ibm_pkg::ibm_rsp_type rsp_ff, nxt_rsp;
    logic [1:0] lvl;
    logic scl_f, sda_f, scl_p_ff, sda_p_ff;
    logic busy_ff, own_ff, nxt_own;
    logic sda_drv_ff, nxt_sda_drv;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bit_ff, nxt_bit;
    logic rsp_valid_ff, nxt_rsp_valid;
    logic tick;

    // ****************************************************************
    // Input synchronisation and bus monitor
    // ****************************************************************
    ibm_sync #(.WIDTH(2)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i({scl_i, sda_i}),
        .level_o(lvl)
    );
    assign scl_f = lvl[1];
    assign sda_f = lvl[0];

    // Conditions seen on the wire, our own included
    wire start_det = scl_f && scl_p_ff && sda_p_ff && !sda_f;
    wire stop_det = scl_f && scl_p_ff && !sda_p_ff && sda_f;
    wire bus_free = !busy_ff && scl_f && sda_f;

    // Previous filtered levels feed the condition detectors
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_p_ff <= 1'b1;
            sda_p_ff <= 1'b1;
        end else begin
            scl_p_ff <= scl_f;
            sda_p_ff <= sda_f;
        end
    end

    // Busy from any START until a STOP
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_ff <= 1'b0;
        end else if (start_det) begin
            busy_ff <= 1'b1;
        end else if (stop_det) begin
            busy_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Phase timing
    // ****************************************************************
    // Hold the divider while a stretched clock stays low, so the high
    // phase we give a slow node is a full half period once released
    wire in_high = (state_ff == ibm_pkg::ST_BIT_HIGH) ||
        (state_ff == ibm_pkg::ST_RS_HIGH) ||
        (state_ff == ibm_pkg::ST_STOP_HIGH);
    wire stretched = in_high && !scl_f;
    wire div_clr = (nxt_state != state_ff) || stretched;

    ibm_tick #(.HALF(HALF)) u_tick (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clear_i(div_clr),
        .tick_o(tick)
    );

    // ****************************************************************
    // Bit decode
    // ****************************************************************
    wire ack_slot = (bit_ff == ibm_pkg::ACK_SLOT);
    // Our wanted drive: write bits from the shifter, read ack from nack
    wire want_low = cmd_ff.read ? (ack_slot && !cmd_ff.nack)
                                : (!ack_slot && !shift_ff[7]);
    // Released but read low while clock high: someone else won
    wire arb_hit = !want_low && !sda_f &&
        (cmd_ff.read ? ack_slot : !ack_slot);
    wire low_ready = tick && !scl_f;
    wire high_done = tick && scl_f;
    wire need_start = cmd_i.start || !own_ff;
    wire accept = cmd_valid_i && cmd_ready_o;

    // Ready only when we own the bus or it is truly idle
    assign cmd_ready_o = (state_ff == ibm_pkg::ST_IDLE) &&
        (own_ff || bus_free);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_sda_drv = sda_drv_ff;
        nxt_shift = shift_ff;
        nxt_bit = bit_ff;
        nxt_own = own_ff;
        nxt_rsp = rsp_ff;
        nxt_rsp_valid = 1'b0;
        unique case (state_ff)
            ibm_pkg::ST_IDLE: begin
                if (accept) begin
                    nxt_shift = cmd_i.data;
                    nxt_bit = ibm_pkg::BIT_FIRST;
                    if (!need_start) begin
                        nxt_state = ibm_pkg::ST_BIT_LOW;
                    end else if (own_ff) begin
                        nxt_state = ibm_pkg::ST_RS_LOW;
                    end else begin
                        nxt_state = ibm_pkg::ST_START;
                    end
                end
            end
            ibm_pkg::ST_RS_LOW: begin
                // Release data while our clock is low
                if (!scl_f) begin
                    nxt_sda_drv = 1'b0;
                end
                if (low_ready) begin
                    nxt_state = ibm_pkg::ST_RS_HIGH;
                end
            end
            ibm_pkg::ST_RS_HIGH: begin
                if (high_done) begin
                    nxt_state = ibm_pkg::ST_START;
                end
            end
            ibm_pkg::ST_START: begin
                // Data falls with the clock high
                if (scl_f) begin
                    nxt_sda_drv = 1'b1;
                end
                if (high_done) begin
                    nxt_own = 1'b1;
                    nxt_state = ibm_pkg::ST_BIT_LOW;
                end
            end
            ibm_pkg::ST_BIT_LOW: begin
                if (!scl_f) begin
                    nxt_sda_drv = want_low;
                end
                if (low_ready) begin
                    nxt_state = ibm_pkg::ST_BIT_HIGH;
                end
            end
            ibm_pkg::ST_BIT_HIGH: begin
                // Sample at the end of the stable high phase
                if (high_done) begin
                    nxt_shift = {shift_ff[6:0], sda_f};
                    nxt_bit = bit_ff + ibm_pkg::BIT_STEP;
                    if (arb_hit) begin
                        nxt_own = 1'b0;
                        nxt_sda_drv = 1'b0;
                        nxt_rsp.arb_lost = 1'b1;
                        nxt_rsp_valid = 1'b1;
                        nxt_state = ibm_pkg::ST_IDLE;
                    end else if (ack_slot) begin
                        nxt_rsp.data = shift_ff;
                        nxt_rsp.acked = !sda_f;
                        nxt_rsp.arb_lost = 1'b0;
                        nxt_rsp_valid = 1'b1;
                        nxt_state = cmd_ff.stop ? ibm_pkg::ST_STOP_LOW
                                                : ibm_pkg::ST_IDLE;
                    end else begin
                        nxt_state = ibm_pkg::ST_BIT_LOW;
                    end
                end
            end
            ibm_pkg::ST_STOP_LOW: begin
                if (!scl_f) begin
                    nxt_sda_drv = 1'b1;
                end
                if (low_ready) begin
                    nxt_state = ibm_pkg::ST_STOP_HIGH;
                end
            end
            ibm_pkg::ST_STOP_HIGH: begin
                if (high_done) begin
                    nxt_state = ibm_pkg::ST_STOP_REL;
                end
            end
            ibm_pkg::ST_STOP_REL: begin
                // Data rises with the clock high
                nxt_sda_drv = 1'b0;
                if (tick) begin
                    nxt_own = 1'b0;
                    nxt_state = ibm_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Command held for the whole byte
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_ff <= '0;
        end else if (accept) begin
            cmd_ff <= cmd_i;
        end
    end

    // Sequencer state and shifter
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ibm_pkg::ST_IDLE;
            shift_ff <= 8'h00;
            bit_ff <= 4'h0;
            own_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            bit_ff <= nxt_bit;
            own_ff <= nxt_own;
        end
    end

    // Pin drive and answer
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_drv_ff <= 1'b0;
            rsp_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end else begin
            sda_drv_ff <= nxt_sda_drv;
            rsp_ff <= nxt_rsp;
            rsp_valid_ff <= nxt_rsp_valid;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Clock pulled low in low phases and while we park an owned bus
    wire scl_low = (state_ff == ibm_pkg::ST_BIT_LOW) ||
        (state_ff == ibm_pkg::ST_RS_LOW) ||
        (state_ff == ibm_pkg::ST_STOP_LOW) ||
        ((state_ff == ibm_pkg::ST_IDLE) && own_ff);
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_low;
    assign sda_oe_o = sda_drv_ff;
    assign rsp_valid_o = rsp_valid_ff;
    assign rsp_o = rsp_ff;
    assign bus_busy_o = busy_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    wire cond_state = (state_ff == ibm_pkg::ST_START) ||
        (state_ff == ibm_pkg::ST_STOP_REL);

    a_pins_never_high: assert property (!scl_o && !sda_o)
        else $error("bus pin driven high");
    a_data_chg_low: assert property (
        $changed(sda_oe_o) && !$past(cond_state) |-> !$past(scl_f))
        else $error("data changed while clock high");
    a_start_clk_high: assert property (
        $rose(sda_oe_o) && $past(state_ff) == ibm_pkg::ST_START
        |-> $past(scl_f) && !scl_oe_o)
        else $error("start without clock high");
    a_busy_on_start: assert property (start_det |=> busy_ff)
        else $error("busy not set after start");
    a_free_on_stop: assert property (
        stop_det && !start_det |=> !busy_ff)
        else $error("busy not cleared after stop");
    a_no_takeover: assert property (
        state_ff == ibm_pkg::ST_IDLE && !own_ff && busy_ff |-> !cmd_ready_o)
        else $error("ready while another master owns bus");
    a_arb_backoff: assert property (
        rsp_valid_o && rsp_o.arb_lost
        |-> !sda_oe_o && !scl_oe_o && !own_ff ##1 !scl_oe_o)
        else $error("lines held after arbitration loss");
    a_ack_release: assert property (
        state_ff == ibm_pkg::ST_BIT_HIGH && ack_slot && !cmd_ff.read
        |-> !sda_oe_o)
        else $error("data held in write acknowledge slot");
    a_stretch_wait: assert property (
        stretched |=> state_ff == $past(state_ff) && !scl_oe_o)
        else $error("moved on while clock stretched");
    a_byte_nine: assert property (
        rsp_valid_o && !rsp_o.arb_lost |-> bit_ff == 4'h9)
        else $error("answer not after ninth clock");

    c_write_acked: cover property (rsp_valid_o && rsp_o.acked);
    c_arb_lost: cover property (rsp_valid_o && rsp_o.arb_lost);
    c_rep_start: cover property (state_ff == ibm_pkg::ST_RS_HIGH ##1
        state_ff == ibm_pkg::ST_START);
    c_stop_done: cover property (stop_det && !own_ff);

endmodule : ibm_master

// ===== bench/ibm_slave_model.sv
/* Behavioural target on the two-wire bus: seven bit address, acks
   writes, returns one fixed byte on reads, may stretch the clock.
   Assumes the bench resolves both wires as wired-AND with pull-ups. */
`timescale 1ns/10ps
module ibm_slave_model #(
    parameter logic [3:0] FIXED = 4'h5, // Arbitrary fixed nibble
    parameter logic [7:0] RD_BYTE = 8'h3c
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic addr_strap_bit0_i,
    input wire logic addr_strap_bit1_i,
    input wire logic addr_strap_bit2_i,
    input wire logic [15:0] stretch_ns_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    output logic [7:0] rx_byte_o
);
    logic [7:0] shift_ff;
    int bit_cnt;
    logic addr_ph, sel, rd, m_ack;
    // ****
    // Wire reactions, edge driven so no clock of its own is needed
    // ****
    initial begin
        {scl_oe_o, sda_oe_o, addr_ph, sel, rd, m_ack} = 6'h00;
        bit_cnt = 0;
        shift_ff = 8'h00;
        rx_byte_o = 8'h00;
    end
    // START or repeated START restarts the address phase
    always @(negedge sda_i) if (scl_i === 1'b1) begin
        addr_ph = 1'b1;
        sel = 1'b0;
        bit_cnt = 0;
    end
    // STOP frees the target; it never makes START or STOP itself
    always @(posedge sda_i) if (scl_i === 1'b1) begin
        addr_ph = 1'b0;
        sel = 1'b0;
    end
    // Bits are taken while the clock is high, MSB first
    always @(posedge scl_i) begin
        if (bit_cnt < 8) shift_ff = {shift_ff[6:0], sda_i};
        else m_ack = !sda_i;
        bit_cnt++;
    end
    // Data changes only with the clock low; lines pulled low or released
    always @(negedge scl_i) begin
        if (bit_cnt == 8 && addr_ph) begin
            sel = shift_ff[7:1] == {FIXED, addr_strap_bit2_i,
                addr_strap_bit1_i, addr_strap_bit0_i};
            rd = shift_ff[0];
            addr_ph = 1'b0;
            sda_oe_o <= #5 sel;
        end else if (bit_cnt == 8) begin
            if (sel && !rd) rx_byte_o = shift_ff;
            sda_oe_o <= #5 sel && !rd;
        end else if (bit_cnt >= 9) begin
            bit_cnt = 0;
            if (rd && !m_ack) sel = 1'b0; // Not-acknowledge ends a read
            sda_oe_o <= #5 sel && rd && !RD_BYTE[7];
            // Slow target: hold the clock low, which is never an error
            if (sel && stretch_ns_i != 16'h0000) begin
                scl_oe_o = 1'b1;
                #(stretch_ns_i);
                scl_oe_o = 1'b0;
            end
        end else if (sel && rd) sda_oe_o <= #5 !RD_BYTE[7 - bit_cnt];
    end
endmodule : ibm_slave_model

// ===== bench/test_ibm_master.sv
/* Bench for the bus master: a table of byte commands against the
   target model, then stretching, arbitration loss and reset checks.
   Assumes a wired-AND of all enables with pull-ups on both wires. */
`timescale 1ns/10ps
module test_ibm_master;
    localparam int HALF = 8; // Short half period keeps the run brief
    typedef struct {
        ibm_pkg::ibm_cmd_type cmd;
        logic [7:0] data;
        logic acked;
        int rises;
    } ibm_row_type;
    logic clk_i, nrst_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, bus_busy_o;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl_oe, m_sda_oe, tb_sda_oe;
    ibm_pkg::ibm_cmd_type cmd_i;
    ibm_pkg::ibm_rsp_type rsp_o;
    logic [15:0] stretch_ns;
    logic [7:0] rx_byte;
    int errors, cmp_count, cycles, rises, cyc, i;
    ibm_row_type rows [5];
    // Open drain wires: any enable pulls low, else the pull-up wins
    wire logic scl = !(scl_oe_o | m_scl_oe);
    wire logic sda = !(sda_oe_o | m_sda_oe | tb_sda_oe);
    ibm_master #(.HALF(HALF)) dut_u (
        .clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .bus_busy_o(bus_busy_o),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
    ibm_slave_model model_u (
        .scl_i(scl), .sda_i(sda), .addr_strap_bit0_i(1'b1),
        .addr_strap_bit1_i(1'b1), .addr_strap_bit2_i(1'b0),
        .stretch_ns_i(stretch_ns), .scl_oe_o(m_scl_oe),
        .sda_oe_o(m_sda_oe), .rx_byte_o(rx_byte));
    // ****
    // Clock, bus clock counter and hang guard
    // ****
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge scl) rises++;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            stop_test();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Ready may stay low for a whole STOP, so the wait is bounded
    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            #2;
            n++;
        end
        // A bus that never frees up is a failure, not a silent skip
        if (cmd_ready_o !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask : wait_ready
    // Wait for ready, offer one command for a single clock, then wait for the answer
    task automatic do_cmd(input ibm_pkg::ibm_cmd_type c);
        wait_ready();
        rises = 0;
        cmd_i = c;
        cmd_valid_i = 1'b1;
        @(posedge clk_i);
        #2;
        cmd_valid_i = 1'b0;
        cyc = 0;
        while (rsp_valid_o !== 1'b1 && cyc < 4000) begin
            @(posedge clk_i);
            #2;
            cyc++;
        end
        if (rsp_valid_o !== 1'b1) begin
            errors++;
            stop_test();
        end
        check({scl_o, sda_o}, 16'h0);
    endtask : do_cmd
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // ****
    // Main sequence
    // ****
    initial begin
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        rises = 0;
        nrst_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_i = 12'h000;
        tb_sda_oe = 1'b0;
        stretch_ns = 16'h0000;
        // Address write, data, repeated START read, NACK read, no target
        rows[0] = '{12'h856, 8'h56, 1'b1, 9};
        rows[1] = '{12'h0a5, 8'ha5, 1'b1, 9};
        rows[2] = '{12'h857, 8'h57, 1'b1, 10};
        rows[3] = '{12'h700, 8'h3c, 1'b0, 9};
        rows[4] = '{12'hc58, 8'h58, 1'b0, 9};
        repeat (4) @(posedge clk_i);
        #2 check({scl_oe_o, sda_oe_o, rsp_valid_o, bus_busy_o, cmd_ready_o},
            16'h1);
        check(rsp_o, 16'h0);
        repeat (4) @(posedge clk_i);
        #2 nrst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        #2;
        for (i = 0; i < 5; i++) begin
            do_cmd(rows[i].cmd);
            check(rsp_o.data, rows[i].data);
            check(rsp_o.acked, rows[i].acked);
            check(rsp_o.arb_lost, 1'b0);
            check(bus_busy_o, 1'b1);
            check(16'(rises), rows[i].rises);
        end
        check(rx_byte, 8'ha5);
        // A target holding the clock low delays the next byte, no error
        stretch_ns = 16'h4e20;
        do_cmd(12'h856);
        do_cmd(12'h45a);
        stretch_ns = 16'h0000;
        check(cyc > 400, 1'b1);
        check(rsp_o.acked, 1'b1);
        // Another master pulls data low while ours sends a one
        wait_ready();
        fork
            do_cmd(12'hc80);
            begin
                wait (scl === 1'b0);
                @(posedge clk_i);
                #2 tb_sda_oe = 1'b1;
            end
        join
        check(rsp_o.arb_lost, 1'b1);
        repeat (20) @(posedge clk_i);
        #2 check({bus_busy_o, cmd_ready_o, scl_oe_o, sda_oe_o}, 16'h8);
        tb_sda_oe = 1'b0;
        repeat (20) @(posedge clk_i);
        #2 check({bus_busy_o, cmd_ready_o, scl_oe_o, sda_oe_o}, 16'h4);
        // Reset in mid-byte: both lines let go, ready right after release
        wait_ready();
        cmd_i = 12'hc58;
        cmd_valid_i = 1'b1;
        @(posedge clk_i);
        #2 cmd_valid_i = 1'b0;
        repeat (30) @(posedge clk_i);
        #2 nrst_i = 1'b0;
        @(posedge clk_i);
        #2 check({scl_oe_o, sda_oe_o, rsp_valid_o, bus_busy_o}, 16'h0);
        @(posedge clk_i);
        #2 nrst_i = 1'b1;
        repeat (2) begin
            @(posedge clk_i);
            #2 check({scl_oe_o, sda_oe_o, rsp_valid_o, bus_busy_o,
                cmd_ready_o}, 16'h1);
        end
        // First byte after the reset runs normally to an unanswered address
        do_cmd(12'hc58);
        check(rsp_o, 16'h160);
        stop_test();
    end
endmodule : test_ibm_master
